// ==== core/sfdpet_field_pack.sv ====
`include "sfdpet_defines.svh"

// places the four erase time fields and the multiplier into one double word
module sfdpet_field_pack
(
    input sfdpet_pkg::sfdpet_etime_set_type etimes,
    input logic [`SFDPET_MULT_W-1:0] mult_n,
    output logic [31:0] dword
);

    localparam int FW = `SFDPET_CNT_W + `SFDPET_UNIT_W;

    assign dword[`SFDPET_MULT_LSB +: `SFDPET_MULT_W] = mult_n;

    genvar i;
    generate
        for (i = 0; i < `SFDPET_NUM_TYPES; i++)
        begin : g_type
            // count in the low bits of each 7-bit slot, unit above it
            assign dword[`SFDPET_FIELD_BASE + i * `SFDPET_FIELD_STRIDE +: FW] =
                {etimes[i].unit, etimes[i].count};
        end
    endgenerate

endmodule

// ==== core/sfdpet_table.sv ====
// What this block does
// - offset 24h reads 00h, type four unsupported
// - offset 25h reads FFh, no type four opcode
// - unit codes mean 1ms, 16ms, 128ms, 1s
// - type three: unit 10b, count 00011b, 512ms
// - bits 3:0 hold N=2, sixfold maximum
// - unsupported types carry 11b and 11111b
// - offsets 26h-29h read F2h, FFh, 0Fh, FFh
`include "sfdpet_defines.svh"

module sfdpet_table
#(
    parameter logic [`SFDPET_UNIT_W-1:0] ET3_UNIT = `SFDPET_ET3_UNIT,
    parameter logic [`SFDPET_CNT_W-1:0] ET3_COUNT = `SFDPET_ET3_COUNT,
    parameter logic [`SFDPET_MULT_W-1:0] MULT_N = `SFDPET_MULT_N
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    input sfdpet_pkg::sfdpet_rd_req_type rd_req,
    output sfdpet_pkg::sfdpet_rd_rsp_type rd_rsp,
    input sfdpet_pkg::sfdpet_tq_req_type tq_req,
    output sfdpet_pkg::sfdpet_tq_rsp_type tq_rsp,
    output logic image_ok
);

    sfdpet_pkg::sfdpet_etime_set_type etimes;
    logic [31:0] dword10;

    // type three is the only erase type with a real entry
    always_comb
    begin
        etimes = '0;
        for (int i = 0; i < `SFDPET_NUM_TYPES; i++)
        begin
            etimes[i].unit = sfdpet_pkg::sfdpet_unit_type'(`SFDPET_RSV_UNIT);
            etimes[i].count = `SFDPET_RSV_COUNT;
        end
        etimes[2].unit = sfdpet_pkg::sfdpet_unit_type'(ET3_UNIT);
        etimes[2].count = ET3_COUNT;
    end

    sfdpet_field_pack u_pack
    (
        .etimes(etimes),
        .mult_n(MULT_N),
        .dword(dword10)
    );

    // byte k of a little-endian double word
    function automatic logic [7:0] byte_of(input logic [31:0] dw, input logic [1:0] k);
        logic [7:0] b;
        b = dw[k * 8 +: 8];
        return b;
    endfunction

    // mapped bytes; any other offset reads FFh with hit low
    function automatic logic [8:0] lookup(input logic [7:0] ofs, input logic [31:0] dw);
        logic [8:0] res;
        res = {1'b0, `SFDPET_MISS_VAL};
        unique case (ofs)
            `SFDPET_OFS_ET4_SIZE:
                res = {1'b1, `SFDPET_ET4_SIZE_VAL};
            `SFDPET_OFS_ET4_OPCODE:
                res = {1'b1, `SFDPET_ET4_OPCODE_VAL};
            `SFDPET_OFS_DW10_B0:
                res = {1'b1, byte_of(dw, 2'h0)};
            `SFDPET_OFS_DW10_B1:
                res = {1'b1, byte_of(dw, 2'h1)};
            `SFDPET_OFS_DW10_B2:
                res = {1'b1, byte_of(dw, 2'h2)};
            `SFDPET_OFS_DW10_B3:
                res = {1'b1, byte_of(dw, 2'h3)};
            default:
                res = {1'b0, `SFDPET_MISS_VAL};
        endcase
        return res;
    endfunction

    function automatic logic [23:0] unit_ms(input sfdpet_pkg::sfdpet_unit_type u);
        logic [23:0] ms;
        ms = `SFDPET_UNIT0_MS;
        unique case (u)
            sfdpet_pkg::unit_1ms:
                ms = `SFDPET_UNIT0_MS;
            sfdpet_pkg::unit_16ms:
                ms = `SFDPET_UNIT1_MS;
            sfdpet_pkg::unit_128ms:
                ms = `SFDPET_UNIT2_MS;
            sfdpet_pkg::unit_1s:
                ms = `SFDPET_UNIT3_MS;
        endcase
        return ms;
    endfunction

    // byte read path
    sfdpet_pkg::sfdpet_rd_rsp_type next_rd_rsp;
    logic [8:0] hit_byte;

    always_comb
    begin
        hit_byte = lookup(rd_req.offset, dword10);
        next_rd_rsp.valid = rd_req.valid;
        next_rd_rsp.hit = rd_req.valid & hit_byte[8];
        next_rd_rsp.data = rd_req.valid ? hit_byte[7:0] : 8'h00;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rd_rsp <= '0;
        end
        else
        begin
            rd_rsp <= next_rd_rsp;
        end
    end

    // timing query path: every erase type is decoded up front, a query only selects
    function automatic sfdpet_pkg::sfdpet_etime_type field_of
    (
        input logic [31:0] dw,
        input logic [1:0] idx
    );
        sfdpet_pkg::sfdpet_etime_type fld;
        fld = dw[`SFDPET_FIELD_BASE + idx * `SFDPET_FIELD_STRIDE
                 +: `SFDPET_CNT_W + `SFDPET_UNIT_W];
        return fld;
    endfunction

    // all-ones unit and count mark an erase type that does not exist
    function automatic logic is_reserved(input sfdpet_pkg::sfdpet_etime_type fld);
        logic rsv;
        rsv = (fld.unit == sfdpet_pkg::sfdpet_unit_type'(`SFDPET_RSV_UNIT))
              && (fld.count == `SFDPET_RSV_COUNT);
        return rsv;
    endfunction

    // multiplier from typical to maximum time, 2*(N+1)
    logic [4:0] mult;

    always_comb
    begin
        mult = 5'({dword10[`SFDPET_MULT_LSB +: `SFDPET_MULT_W], 1'b0} + 5'h02);
    end

    logic [`SFDPET_NUM_TYPES-1:0] type_rsv;
    logic [`SFDPET_NUM_TYPES-1:0][23:0] type_typ;
    logic [`SFDPET_NUM_TYPES-1:0][23:0] type_max;

    genvar g;
    generate
        for (g = 0; g < `SFDPET_NUM_TYPES; g++)
        begin : g_decode
            sfdpet_pkg::sfdpet_etime_type fld;
            logic [23:0] typ;
            // wide enough for the largest count, unit and multiplier together
            logic [28:0] max_full;

            assign fld = field_of(dword10, 2'(g));
            assign typ = 24'((fld.count + 24'h000001) * unit_ms(fld.unit));
            assign max_full = 29'(typ * mult);
            assign type_rsv[g] = is_reserved(fld);
            assign type_typ[g] = typ;
            assign type_max[g] = max_full[23:0];
        end
    endgenerate

    sfdpet_pkg::sfdpet_tq_rsp_type next_tq_rsp;
    logic rsv;

    always_comb
    begin
        rsv = type_rsv[tq_req.etype];
        next_tq_rsp.valid = tq_req.valid;
        next_tq_rsp.present = tq_req.valid & ~rsv;
        next_tq_rsp.typ_ms = (tq_req.valid && !rsv) ? type_typ[tq_req.etype] : 24'h000000;
        next_tq_rsp.max_ms = (tq_req.valid && !rsv) ? type_max[tq_req.etype] : 24'h000000;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tq_rsp <= '0;
        end
        else
        begin
            tq_rsp <= next_tq_rsp;
        end
    end

    // flags a parameter set that no longer matches the published word, or a
    // decode that disagrees with it (only type three may read as present)
    logic next_image_ok;
    logic decode_ok;

    always_comb
    begin
        decode_ok = 1'b1;
        for (int i = 0; i < `SFDPET_NUM_TYPES; i++)
        begin
            if (type_rsv[i] != 1'(i != 2))
            begin
                decode_ok = 1'b0;
            end
        end
        next_image_ok = (dword10 == `SFDPET_DW10_VAL) && decode_ok;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            image_ok <= 1'b0;
        end
        else
        begin
            image_ok <= next_image_ok;
        end
    end

endmodule

// ==== pkg/sfdpet_defines.svh ====
`ifndef SFDPET_DEFINES_SVH
`define SFDPET_DEFINES_SVH

// byte offsets as the host presents them (relative to the parameter base)
`define SFDPET_OFS_ET4_SIZE 8'h24
`define SFDPET_OFS_ET4_OPCODE 8'h25
`define SFDPET_OFS_DW10_B0 8'h26
`define SFDPET_OFS_DW10_B1 8'h27
`define SFDPET_OFS_DW10_B2 8'h28
`define SFDPET_OFS_DW10_B3 8'h29

// the same bytes counted from the start of the table
`define SFDPET_TBL_ET4_SIZE 8'h22
`define SFDPET_TBL_ET4_OPCODE 8'h23

// byte values
`define SFDPET_ET4_SIZE_VAL 8'h00
`define SFDPET_ET4_OPCODE_VAL 8'hFF
`define SFDPET_MISS_VAL 8'hFF
`define SFDPET_DW10_VAL 32'hFF0FFFF2

// field layout of the erase timing double word
`define SFDPET_MULT_LSB 0
`define SFDPET_MULT_W 4
`define SFDPET_FIELD_BASE 4
`define SFDPET_FIELD_STRIDE 7
`define SFDPET_CNT_W 5
`define SFDPET_UNIT_W 2
`define SFDPET_NUM_TYPES 4

// field values
`define SFDPET_ET3_UNIT 2'h2
`define SFDPET_ET3_COUNT 5'h03
`define SFDPET_RSV_UNIT 2'h3
`define SFDPET_RSV_COUNT 5'h1F
`define SFDPET_MULT_N 4'h2

// unit sizes in milliseconds
`define SFDPET_UNIT0_MS 24'h000001
`define SFDPET_UNIT1_MS 24'h000010
`define SFDPET_UNIT2_MS 24'h000080
`define SFDPET_UNIT3_MS 24'h0003E8

`endif

// ==== pkg/sfdpet_pkg.sv ====
`include "sfdpet_defines.svh"

package sfdpet_pkg;

    typedef enum logic [1:0]
    {
        unit_1ms = 2'b00,
        unit_16ms = 2'b01,
        unit_128ms = 2'b10,
        unit_1s = 2'b11
    } sfdpet_unit_type;

    typedef struct packed
    {
        sfdpet_unit_type unit;
        logic [`SFDPET_CNT_W-1:0] count;
    } sfdpet_etime_type;

    typedef sfdpet_etime_type [`SFDPET_NUM_TYPES-1:0] sfdpet_etime_set_type;

    typedef struct packed
    {
        logic valid;
        logic [7:0] offset;
    } sfdpet_rd_req_type;

    typedef struct packed
    {
        logic valid;
        logic hit;
        logic [7:0] data;
    } sfdpet_rd_rsp_type;

    typedef struct packed
    {
        logic valid;
        logic [1:0] etype;
    } sfdpet_tq_req_type;

    typedef struct packed
    {
        logic valid;
        logic present;
        logic [23:0] typ_ms;
        logic [23:0] max_ms;
    } sfdpet_tq_rsp_type;

endpackage

// ==== tb/sfdpet_host_model.sv ====
module sfdpet_host_model
(
    input wire logic ref_clk,
    input sfdpet_pkg::sfdpet_tq_rsp_type tq_rsp,
    output logic [23:0] timeout_ms
);
    timeunit 1ns;
    timeprecision 1ps;
    // no timeout is derived for an erase type marked reserved
    always_ff @(posedge ref_clk)
        timeout_ms <= (tq_rsp.valid && tq_rsp.present) ? tq_rsp.max_ms : 24'h000000;
endmodule

// ==== tb/sfdpet_table_properties.sv ====
module sfdpet_table_checker
(
    input wire logic ref_clk,
    input wire logic resetn,
    input sfdpet_pkg::sfdpet_rd_req_type rd_req,
    input sfdpet_pkg::sfdpet_rd_rsp_type rd_rsp,
    input sfdpet_pkg::sfdpet_tq_req_type tq_req,
    input sfdpet_pkg::sfdpet_tq_rsp_type tq_rsp,
    input wire logic image_ok
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence s_rd(logic [7:0] o);
        rd_req.valid && rd_req.offset == o;
    endsequence
    sequence s_tq(logic [1:0] t);
        tq_req.valid && tq_req.etype == t;
    endsequence
    a_et4_size: assert property (s_rd(8'h24)
        |=> rd_rsp.valid && rd_rsp.hit && rd_rsp.data == 8'h00) else $error("size byte wrong");
    a_et4_opcode: assert property (s_rd(8'h25)
        |=> rd_rsp.valid && rd_rsp.hit && rd_rsp.data == 8'hFF) else $error("opcode byte wrong");
    a_dword_bytes: assert property (rd_req.valid && rd_req.offset inside {[8'h26:8'h29]}
        |=> rd_rsp.hit && rd_rsp.data == 8'(32'hFF0FFFF2 >> (8 * ($past(rd_req.offset) - 8'h26))))
        else $error("timing dword byte wrong");
    a_et3_time: assert property (s_tq(2'h2)
        |=> tq_rsp.present && tq_rsp.typ_ms == 24'h000200) else $error("type three time wrong");
    a_max_mult: assert property (tq_rsp.valid |-> tq_rsp.max_ms == tq_rsp.typ_ms * 6)
        else $error("maximum multiplier wrong");
    a_rsv_absent: assert property (tq_req.valid && tq_req.etype != 2'h2
        |=> tq_rsp.valid && !tq_rsp.present && tq_rsp.typ_ms == 24'h0) else $error("reserved seen");
    a_image_ok: assert property ($past(resetn) |-> image_ok)
        else $error("image flag low");
endmodule

// ==== tb/tb_sfdpet_table.sv ====
module tb_sfdpet_table;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    sfdpet_pkg::sfdpet_rd_req_type rd_req = '0;
    sfdpet_pkg::sfdpet_rd_rsp_type rd_rsp;
    sfdpet_pkg::sfdpet_tq_req_type tq_req = '0;
    sfdpet_pkg::sfdpet_tq_rsp_type tq_rsp;
    logic image_ok;
    logic [23:0] timeout_ms;
    logic [8:0] rd_q[$];
    logic [48:0] tq_q[$];
    int num_errors = 0;
    int checked = 0;
    sfdpet_table sfdpet_table_inst (.ref_clk(ref_clk), .resetn(resetn), .rd_req(rd_req),
        .rd_rsp(rd_rsp), .tq_req(tq_req), .tq_rsp(tq_rsp), .image_ok(image_ok));
    sfdpet_host_model sfdpet_host_model_inst (.ref_clk(ref_clk), .tq_rsp(tq_rsp),
        .timeout_ms(timeout_ms));
    initial forever #2.5 ref_clk = ~ref_clk;
    task automatic end_sim;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(logic ok, string msg);
        checked++;
        if (ok !== 1'b1)
        begin
            num_errors++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask
    function automatic logic [8:0] exp_rd(logic [7:0] o);
        logic [31:0] dw;
        dw = 32'hFF0FFFF2;
        if (o == 8'h24) return 9'h100;
        if (o == 8'h25) return 9'h1FF;
        if (o inside {[8'h26:8'h29]}) return {1'b1, 8'(dw >> (8 * (o - 8'h26)))};
        return 9'h0FF;
    endfunction
    function automatic logic [48:0] exp_tq(logic [1:0] t);
        logic [23:0] typ;
        typ = 24'((3 + 1) * 128);
        if (t == 2'h2) return {1'b1, typ, 24'(typ * 2 * (2 + 1))};
        return 49'h0;
    endfunction
    task automatic step(logic rv, logic [7:0] o, logic tv, logic [1:0] t);
        @(negedge ref_clk);
        rd_req <= {rv, o};
        tq_req <= {tv, t};
        if (rv) rd_q.push_back(exp_rd(o));
        if (tv) tq_q.push_back(exp_tq(t));
    endtask
    logic rd_ok;
    logic tq_ok;
    logic [8:0] rd_exp;
    logic [48:0] tq_exp;
    logic [23:0] exp_timeout = 24'h000000;
    // the host model registers one edge after each timing answer
    always @(negedge ref_clk)
    begin
        if (resetn)
            check(timeout_ms === exp_timeout, "host timeout");
        exp_timeout = 24'h000000;
        if (resetn && rd_rsp.valid === 1'b1)
        begin
            rd_ok = rd_q.size() > 0;
            rd_exp = rd_ok ? rd_q.pop_front() : 9'h000;
            check(rd_ok && {rd_rsp.hit, rd_rsp.data} === rd_exp, "read byte");
        end
        if (resetn && tq_rsp.valid === 1'b1)
        begin
            tq_ok = tq_q.size() > 0;
            tq_exp = tq_ok ? tq_q.pop_front() : 49'h0;
            check(tq_ok && tq_rsp[48:0] === tq_exp, "timing answer");
            exp_timeout = tq_exp[48] ? tq_exp[23:0] : 24'h000000;
        end
    end
    initial
    begin
        void'($urandom(32'h8863));
        repeat (20) @(negedge ref_clk);
        resetn <= 1'b1;
        repeat (2) @(negedge ref_clk);
        check(image_ok === 1'b1, "image flag");
        for (int i = 0; i < 6; i++)
            step(1'b1, 8'h24 + 8'(i), 1'b1, 2'(i));
        repeat (300)
            step(1'($urandom), 8'h20 + 8'($urandom % 16), 1'($urandom), 2'($urandom));
        step(1'b0, 8'h00, 1'b0, 2'h0);
        repeat (3) @(negedge ref_clk);
        check(rd_q.size() == 0 && tq_q.size() == 0, "missing answers");
        end_sim();
    end
    initial
    begin
        #20000;
        num_errors++;
        end_sim();
    end
endmodule

bind sfdpet_table sfdpet_table_checker sfdpet_table_checker_inst (.ref_clk(ref_clk),
    .resetn(resetn), .rd_req(rd_req), .rd_rsp(rd_rsp), .tq_req(tq_req), .tq_rsp(tq_rsp),
    .image_ok(image_ok));
